// [hdl/sdiu_top.sv]
module sdiu_top
  import sdiu_pkg::*;
(
  // System clock
  input wire logic clk_sys,
  // Synchronous reset, low active
  input wire logic reset_n,
  // Request from the sequencer
  input wire sdiu_req_t req,
  // Divide in progress
  output logic busy,
  // Answer to the sequencer
  output sdiu_rsp_t rsp
);
  // Divider states
  typedef enum logic [1:0] {
    SDIU_IDLE = 2'h0,
    SDIU_RUN = 2'h1,
    SDIU_FIX = 2'h2
  } sdiu_state_t;

  // All state of the unit
  typedef struct packed {
    // Divider sequencing
    sdiu_state_t state;
    // Width of the running divide
    logic wide;
    // Result signs, fixed at the start
    logic negQuot;
    logic negRem;
    // Steps left in the run
    logic [SDIU_CNT_W-1:0] count;
    // Dividend bits out, quotient bits in
    logic [SDIU_WIDE_W-1:0] quot;
    // Partial remainder with one guard bit
    logic [SDIU_WIDE_W:0] rem;
    // Divisor magnitude
    logic [SDIU_WIDE_W-1:0] divisor;
    // Mirrors the busy output
    logic busy;
    // Answer register, drives rsp
    sdiu_rsp_t rsp;
  } sdiu_regs_t;

  // Registered state and its next value
  sdiu_regs_t r_q;
  sdiu_regs_t r_d;
  // Step result for plus-one and minus-one
  logic [SDIU_WIDE_W-1:0] stepResult;
  // Sign-extended operands
  logic [SDIU_WIDE_W-1:0] dividend;
  logic [SDIU_WIDE_W-1:0] divisorIn;
  // Magnitudes
  logic [SDIU_WIDE_W-1:0] dividendMag;
  logic [SDIU_WIDE_W-1:0] divisorMag;
  // Trial subtraction
  logic [SDIU_WIDE_W:0] trialRem;
  logic [SDIU_WIDE_W:0] trialDiff;
  // Final signed values
  logic [SDIU_WIDE_W-1:0] quotOut;
  logic [SDIU_WIDE_W-1:0] remOut;

  // Shared incrementer and decrementer
  // Serves both steps; only taken while idle
  sdiu_step_unit stepper
  (
    .value(req.firstSourceOperand),
    .wide(req.wide),
    .down(req.op == SDIU_OP_MINUS_ONE),
    .result(stepResult)
  );

  // Operand preparation and next-state logic
  always_comb
  begin
    r_d = r_q;
    // Answer strobe lasts one cycle
    r_d.rsp.valid = 1'b0;
    r_d.rsp.skipped = 1'b0;
    // Narrow operands use their low word, sign extended
    if (req.wide)
    begin
      // Wide form takes the full words
      dividend = req.firstSourceOperand;
      divisorIn = req.secondSourceOperand;
    end
    else
    begin
      // Upper operand halves are ignored
      dividend = {{SDIU_WORD_W{req.firstSourceOperand[SDIU_WORD_W-1]}},
                  req.firstSourceOperand[SDIU_WORD_W-1:0]};
      divisorIn = {{SDIU_WORD_W{req.secondSourceOperand[SDIU_WORD_W-1]}},
                   req.secondSourceOperand[SDIU_WORD_W-1:0]};
    end
    // Magnitudes; the most negative value maps to itself, unsigned ok
    dividendMag = dividend[SDIU_WIDE_W-1] ? (SDIU_ZERO - dividend) : dividend;
    divisorMag = divisorIn[SDIU_WIDE_W-1] ? (SDIU_ZERO - divisorIn)
                                          : divisorIn;
    // Restoring step: shift in the next dividend bit
    // Guard bit flags a negative difference
    trialRem = {r_q.rem[SDIU_WIDE_W-1:0], r_q.quot[SDIU_WIDE_W-1]};
    trialDiff = trialRem - {1'b0, r_q.divisor};
    quotOut = r_q.negQuot ? (SDIU_ZERO - r_q.quot) : r_q.quot;
    remOut = r_q.negRem ? (SDIU_ZERO - r_q.rem[SDIU_WIDE_W-1:0])
                        : r_q.rem[SDIU_WIDE_W-1:0];
    // Divide sequencing; steps bypass it
    case (r_q.state)
      SDIU_IDLE:
      begin
        // Requests are taken only while idle
        // Unknown op code falls through unanswered
        if (req.valid)
        begin
          if (req.op == SDIU_OP_DIVIDE)
          begin
            if (divisorIn == SDIU_ZERO)
            begin
              r_d.rsp.valid = 1'b1;
              // No write: data and word count kept
              r_d.rsp.skipped = 1'b1;
            end
            else
            begin
              r_d.state = SDIU_RUN;
              r_d.busy = 1'b1;
              r_d.wide = req.wide;
              // Result signs fixed at the start
              r_d.negQuot = dividend[SDIU_WIDE_W-1] ^ divisorIn[SDIU_WIDE_W-1];
              r_d.negRem = dividend[SDIU_WIDE_W-1];
              r_d.divisor = divisorMag;
              // Remainder starts empty
              r_d.rem = {(SDIU_WIDE_W+1){1'b0}};
              // Narrow dividend is pre-shifted so 16 steps suffice
              r_d.quot = req.wide ? dividendMag
                                  : {dividendMag[SDIU_WORD_W-1:0],
                                     {SDIU_WORD_W{1'b0}}};
              r_d.count = req.wide ? SDIU_ITER32 : SDIU_ITER16;
            end
          end
          else if (req.op == SDIU_OP_PLUS_ONE || req.op == SDIU_OP_MINUS_ONE)
          begin
            r_d.rsp.valid = 1'b1;
            r_d.rsp.wordCount = req.wide ? SDIU_WORDS_TWO : SDIU_WORDS_ONE;
            // Unused answer words stay zero
            r_d.rsp.data = {SDIU_ZERO, stepResult};
          end
        end
      end
      SDIU_RUN:
      begin
        // One quotient bit per clock
        if (trialDiff[SDIU_WIDE_W])
        begin
          // Too small to subtract: bit is 0
          r_d.rem = trialRem;
          r_d.quot = {r_q.quot[SDIU_WIDE_W-2:0], 1'b0};
        end
        else
        begin
          // Subtract fits: bit is 1
          r_d.rem = trialDiff;
          r_d.quot = {r_q.quot[SDIU_WIDE_W-2:0], 1'b1};
        end
        // One step consumed
        r_d.count = r_q.count - SDIU_CNT_ONE;
        // Last step moves on to the sign fix
        if (r_q.count == SDIU_CNT_ONE)
        begin
          r_d.state = SDIU_FIX;
        end
      end
      SDIU_FIX:
      begin
        // Signs applied, answer out, idle again
        r_d.state = SDIU_IDLE;
        r_d.busy = 1'b0;
        r_d.rsp.valid = 1'b1;
        if (r_q.wide)
        begin
          r_d.rsp.wordCount = SDIU_WORDS_FOUR;
          // Remainder words above the quotient
          r_d.rsp.data = {remOut, quotOut};
        end
        else
        begin
          r_d.rsp.wordCount = SDIU_WORDS_TWO;
          // Upper answer words stay zero
          r_d.rsp.data = {SDIU_ZERO, remOut[SDIU_WORD_W-1:0],
                          quotOut[SDIU_WORD_W-1:0]};
        end
      end
      default:
      begin
        // Unused state code: recover to idle
        r_d.state = SDIU_IDLE;
        r_d.busy = 1'b0;
      end
    endcase
  end

  // State register with synchronous reset
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      // Clears any stale answer strobe
      r_q <= '0;
    end
    else
    begin
      // Advance every clock
      r_q <= r_d;
    end
  end

  // Outputs straight from flip-flops
  assign busy = r_q.busy;
  assign rsp = r_q.rsp;
endmodule

// [shared/sdiu_pkg.sv]
// Functional notes
// - Signed divide, store quotient and remainder
// - Zero divisor: no write, destination kept
// - 16-bit divide: two words, upper higher
// - Stored value MSB is the sign
// - Plus-one adds one per executing scan
// - 16-bit increment wraps to most negative
// - 32-bit increment wraps to most negative
// - Minus-one subtracts one per executing scan
// - 16-bit decrement wraps to most positive
// - 32-bit decrement wraps to most positive
package sdiu_pkg;
  // Operand word width of one destination point
  localparam int SDIU_WORD_W = 16;
  // Widest operand
  localparam int SDIU_WIDE_W = 32;
  // Step width of the divider counter
  localparam int SDIU_CNT_W = 6;
  // Unit step for plus-one and minus-one
  localparam logic [SDIU_WIDE_W-1:0] SDIU_ONE = 32'h0000_0001;
  // Zero and one constants
  localparam logic [SDIU_WIDE_W-1:0] SDIU_ZERO = 32'h0000_0000;
  localparam logic [SDIU_CNT_W-1:0] SDIU_CNT_ZERO = 6'h00;
  localparam logic [SDIU_CNT_W-1:0] SDIU_CNT_ONE = 6'h01;
  // Iterations for each width
  localparam logic [SDIU_CNT_W-1:0] SDIU_ITER16 = 6'h10;
  localparam logic [SDIU_CNT_W-1:0] SDIU_ITER32 = 6'h20;
  // Destination points written per answer
  localparam logic [2:0] SDIU_WORDS_ONE = 3'h1;
  localparam logic [2:0] SDIU_WORDS_TWO = 3'h2;
  localparam logic [2:0] SDIU_WORDS_FOUR = 3'h4;

  // Instruction selection
  typedef enum logic [1:0] {
    SDIU_OP_DIVIDE = 2'h0,
    SDIU_OP_PLUS_ONE = 2'h1,
    SDIU_OP_MINUS_ONE = 2'h2
  } sdiu_op_t;

  // One request from the sequencer
  typedef struct packed {
    logic valid;
    sdiu_op_t op;
    logic wide;
    logic [SDIU_WIDE_W-1:0] firstSourceOperand;
    logic [SDIU_WIDE_W-1:0] secondSourceOperand;
  } sdiu_req_t;

  // One result for the destination points, lowest word first
  typedef struct packed {
    logic valid;
    logic skipped;
    logic [2:0] wordCount;
    logic [2*SDIU_WIDE_W-1:0] data;
  } sdiu_rsp_t;
endpackage

// [hdl/sdiu_step_unit.sv]
module sdiu_step_unit
  import sdiu_pkg::*;
(
  input wire logic [SDIU_WIDE_W-1:0] value,
  input wire logic wide,
  input wire logic down,
  output logic [SDIU_WIDE_W-1:0] result
);
  // Unsized wrap is the intended behaviour: no saturation here
  logic [SDIU_WIDE_W-1:0] sum;
  logic [SDIU_WORD_W-1:0] narrow;

  // Plus or minus one, two's complement wrap
  always_comb
  begin
    sum = down ? (value - SDIU_ONE) : (value + SDIU_ONE);
    narrow = sum[SDIU_WORD_W-1:0];
    if (wide)
    begin
      result = sum;
    end
    else
    begin
      result = {{SDIU_WORD_W{1'b0}}, narrow};
    end
  end
endmodule

// [test/sdiu_seq_model.sv]
module sdiu_seq
  import sdiu_pkg::*;
(
  input wire logic clk_sys,
  input wire logic contact,
  input wire sdiu_req_t cmd,
  output sdiu_req_t req
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last = 1'b0;
  always @(posedge clk_sys)
  begin
    req <= #1 {contact && !last, cmd[$bits(cmd)-2:0]};
    last <= contact;
  end
endmodule

// [test/sdiu_assertions.sv]
module sdiu_checker
  import sdiu_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire sdiu_req_t req,
  input wire logic busy,
  input wire sdiu_rsp_t rsp
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  // Taken only while idle
  wire tk = req.valid && !busy;
  wire up = tk && req.op == SDIU_OP_PLUS_ONE;
  wire dn = tk && req.op == SDIU_OP_MINUS_ONE;
  wire dv = tk && req.op == SDIU_OP_DIVIDE;
  wire w = req.wide;
  wire [31:0] a = req.firstSourceOperand;
  // Zero test in the selected width
  wire z = w ? req.secondSourceOperand == SDIU_ZERO
    : req.secondSourceOperand[15:0] == 16'h0000;
  property p_up32;
    up && w |=> rsp.valid && rsp.data == {SDIU_ZERO, $past(a) + SDIU_ONE};
  endproperty
  a_up32: assert property (p_up32) else $error("up32");
  property p_up16;
    up && !w |=> rsp.data == {48'h0, 16'($past(a) + SDIU_ONE)};
  endproperty
  a_up16: assert property (p_up16) else $error("up16");
  property p_dn32;
    dn && w |=> rsp.valid && rsp.data == {SDIU_ZERO, $past(a) - SDIU_ONE};
  endproperty
  a_dn32: assert property (p_dn32) else $error("dn32");
  property p_dn16;
    dn && !w |=> rsp.data == {48'h0, 16'($past(a) - SDIU_ONE)};
  endproperty
  a_dn16: assert property (p_dn16) else $error("dn16");
  property p_zero;
    dv && z |=> rsp.valid && rsp.skipped && !busy;
  endproperty
  a_zero: assert property (p_zero) else $error("zero");
  property p_div16;
    dv && !z && !w |=> busy ##17 rsp.valid && rsp.wordCount == 3'h2;
  endproperty
  a_div16: assert property (p_div16) else $error("div16");
  property p_div32;
    dv && !z && w |=> busy ##33 rsp.valid && rsp.wordCount == 3'h4;
  endproperty
  a_div32: assert property (p_div32) else $error("div32");
  property p_idle;
    busy |-> !rsp.valid;
  endproperty
  a_idle: assert property (p_idle) else $error("idle");
endmodule
bind sdiu_top sdiu_checker CHK (.clk_sys(clk_sys), .reset_n(reset_n),
  .req(req), .busy(busy), .rsp(rsp));

// [test/tb_top.sv]
module tb_top
  import sdiu_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, reset_n = 1'b0, contact = 1'b0, busy;
  sdiu_req_t cmd = '0, req;
  sdiu_rsp_t rsp, got;
  int error_cnt = 0, checks_done = 0, seed = 22, nrsp = 0;
  initial forever #5 clk_sys = ~clk_sys;
  sdiu_seq SEQ (.clk_sys(clk_sys), .contact(contact), .cmd(cmd), .req(req));
  sdiu_top DUT (.clk_sys(clk_sys), .reset_n(reset_n), .req(req),
    .busy(busy), .rsp(rsp));
  // Skipped flag only stands with the pulse, so keep each answer
  always @(posedge clk_sys) if (rsp.valid === 1'b1) nrsp <= nrsp + 1;
  always @(posedge clk_sys) if (rsp.valid === 1'b1) got <= rsp;
  task automatic chk(string n, logic [63:0] e, logic [63:0] g);
    checks_done++;
    error_cnt += (g !== e);
    if (g !== e) $display("[FAIL] %s exp %h got %h", n, e, g);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Contact held for hold edges; model in longint, wrapped by casts
  task automatic run(int op, logic w, logic [31:0] a, b, int hold);
    longint x;
    longint y;
    longint v;
    int n0;
    n0 = nrsp;
    x = w ? $signed(a) : $signed(a[15:0]);
    y = w ? $signed(b) : $signed(b[15:0]);
    v = x + 3 - 2 * op;
    cmd = {1'b0, 2'(op), w, a, b};
    contact = 1'b1;
    repeat (hold) @(posedge clk_sys);
    #1 contact = 1'b0;
    for (int k = 0; k < 40 && nrsp == n0; k++) @(posedge clk_sys);
    repeat (3) @(posedge clk_sys);
    #1 chk("count", 64'(n0 + 1), 64'(nrsp));
    if (op == 0 && y == 0)
      chk("skip", 64'h1, 64'(got.skipped));
    else
      chk("words", 64'((op ? 1 : 2) << w), 64'(got.wordCount));
    if (op == 0 && y != 0)
      chk("div", w ? {32'(x % y), 32'(x / y)}
        : {32'h0, 16'(x % y), 16'(x / y)}, got.data);
    if (op != 0)
      chk("step", {32'h0, w ? 32'(v) : {16'h0, 16'(v)}}, got.data);
    $display("op %0d done", op);
  endtask
  // Reset in mid-divide drops the job and idles the outputs
  task automatic reset_mid();
    int n0;
    n0 = nrsp;
    cmd = {1'b0, 2'(SDIU_OP_DIVIDE), 1'b1, 32'h0000_0064, 32'h0000_0007};
    contact = 1'b1;
    repeat (6) @(posedge clk_sys);
    #1 contact = 1'b0;
    reset_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    chk("rst busy", 64'h0, 64'(busy));
    chk("rst valid", 64'h0, 64'(rsp.valid));
    repeat (40) @(posedge clk_sys);
    #1 chk("rst drop", 64'(n0), 64'(nrsp));
    $display("reset test done");
  endtask
  initial
  begin
    repeat (5) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    run(1, 1'b0, 32'h0000_7FFF, '0, 4);
    run(2, 1'b0, 32'h0000_8000, '0, 1);
    run(1, 1'b1, 32'h7FFF_FFFF, '0, 1);
    run(2, 1'b1, 32'h8000_0000, '0, 1);
    run(0, 1'b0, 32'h0000_8000, 32'h0000_FFFF, 1);
    run(0, 1'b1, 32'h8000_0000, 32'hFFFF_FFFF, 3);
    run(0, 1'b0, 32'h0000_0007, 32'h0005_0000, 1);
    run(0, 1'b1, 32'hFFFF_FFF9, 32'h0000_0002, 1);
    reset_mid();
    for (int i = 0; i < 45; i++)
      run(i % 3, i[1], $random(seed), $random(seed) >>> (i % 33), 1);
    finish_test();
  end
  initial
  begin
    #100000 error_cnt++;
    finish_test();
  end
endmodule
